// ---- include/rap_params.svh ----
/*
 * Register offsets, field positions, reset values and codes of the alarm
 * matcher and pin selector.
 * Assumes it is included by its bare name and that byte addresses are used.
 */
`ifndef RAP_PARAMS_SVH
`define RAP_PARAMS_SVH

`define RAP_OFS_CTRL     8'h00
`define RAP_OFS_COMP     8'h18
`define RAP_OFS_ARM      8'h1C
`define RAP_OFS_AMON     8'h20
`define RAP_OFS_ADATE    8'h24
`define RAP_OFS_AHOUR    8'h28
`define RAP_OFS_AMIN     8'h2C
`define RAP_OFS_ASEC     8'h30
`define RAP_OFS_STAT     8'h34
`define RAP_OFS_MASK     8'h38

`define RAP_BIT_FLAG     6
`define RAP_BIT_CAL      2
`define RAP_BIT_PSEL     6
`define RAP_BIT_RATE_LO  4
`define RAP_BIT_RATE_HI  5
`define RAP_BIT_ARM      0
`define RAP_BIT_EVT      0
`define RAP_BIT_PART     7
`define RAP_VAL_MSB      6

`define RAP_RST_FIELD    8'h80
`define RAP_RST_BIT      1'h0
`define RAP_RST_WORD     32'h0000_0000
`define RAP_RST_RATE     2'h0

`define RAP_RATE_1HZ     2'h0
`define RAP_RATE_512HZ   2'h1
`define RAP_RATE_4KHZ    2'h2
`define RAP_RATE_32KHZ   2'h3

`endif

// ---- include/rap_pkg.sv ----
/*
 * Types shared by the alarm matcher and pin selector.
 * Assumes rap_params.svh supplies the numeric constants.
 */
package rap_pkg;

    typedef struct packed {
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } rap_cal_t;

    typedef struct packed {
        logic w32k;
        logic w4k;
        logic w512;
        logic w1;
    } rap_wave_t;

endpackage

// ---- src/rap_alarm_pin.sv ----
/*
 * Alarm matcher, alarm flag, interrupt status and output-pin selector of a
 * real-time-clock companion, with an Avalon-MM register slave.
 * Assumes the live calendar and the one-second tick come from the
 * timekeeping core on clk, and the square waves come from the RTC divider
 * asynchronously.
 */
`timescale 1ns/1ps
`include "rap_params.svh"

// Operation
// [RULE1] Compare alarm fields with live calendar always.
// [RULE2] Five fields; top bit zero means participating.
// [RULE3] No field participating gives alarm every second.
// [RULE4] Participation sets give minute, hour, day rates.
// [RULE5] Odd combinations use the same per-field compare.
// [RULE6] Match sets flag bit 6 only when armed.
// [RULE7] Flag and pin alarm hold until cleared. The code releases the pin when armReg is cleared, while the flag holds.
// [RULE8] Disarming blocks new sets, keeps existing flag.
// [RULE9] Pin function chosen by cal, select, arm.
// [RULE10] Select bit 6 at 18h routes alarm.
// [RULE11] Rate bits 4 and 5 pick wave rate.
// [RULE12] Calibration bit gives 512 Hz, matching continues.
// [RULE13] Continuous frequency hides the alarm on pin.
// [RULE14] Host polls flag or pin, writes zero.
// [RULE15] Leaving calibration restores the selected function.
// [RULE16] Evaluate once per second calendar update.
// [RULE17] Pin driven low while flag set and selected.
module rap_alarm_pin
    import rap_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Timekeeping core
    input  wire rap_cal_t          liveCal,
    input  wire logic              secTick,
    // Divider square waves, asynchronous
    input  wire rap_wave_t         waveIn,
    // Alarm and wave pin
    output logic                   alarmWavePinOut,
    output logic                   alarmWavePinOe,
    // Interrupt
    output logic                   irq
);

    if (ADDR_W < 8) begin : gAddrCheck
        $error("ADDR_W too narrow for the register map");
    end

    function automatic logic fieldHit(input logic [7:0] alarm, input logic [7:0] live);
        fieldHit = alarm[`RAP_BIT_PART] |
                   (alarm[`RAP_VAL_MSB:0] == live[`RAP_VAL_MSB:0]);
    endfunction

    logic        waitReqReg;
    logic [31:0] rdataReg;
    logic        flagReg;
    logic        calReg;
    logic        pselReg;
    logic [1:0]  rateReg;
    logic        armReg;
    logic        statReg;
    logic        maskReg;
    logic        irqReg;
    logic        pinOutReg;
    logic        pinOeReg;
    rap_cal_t    alarmReg;
    rap_wave_t   waveMeta;
    rap_wave_t   waveSync;

    // Bus decode.
    wire logic [7:0] addr   = avs_address[7:0];
    wire logic       req    = avs_read | avs_write;
    wire logic       wrTake = avs_write & ~waitReqReg & avs_byteenable[0];
    wire logic       rdTake = avs_read & waitReqReg;
    wire logic [7:0] wd     = avs_writedata[7:0];
    wire logic       wrCtrl = wrTake & (addr == `RAP_OFS_CTRL);
    wire logic       wrComp = wrTake & (addr == `RAP_OFS_COMP);
    wire logic       wrArm  = wrTake & (addr == `RAP_OFS_ARM);
    wire logic       wrStat = wrTake & (addr == `RAP_OFS_STAT);
    wire logic       wrMask = wrTake & (addr == `RAP_OFS_MASK);
    wire logic       wrAMon = wrTake & (addr == `RAP_OFS_AMON);
    wire logic       wrADat = wrTake & (addr == `RAP_OFS_ADATE);
    wire logic       wrAHr  = wrTake & (addr == `RAP_OFS_AHOUR);
    wire logic       wrAMin = wrTake & (addr == `RAP_OFS_AMIN);
    wire logic       wrASec = wrTake & (addr == `RAP_OFS_ASEC);

    // [RULE1] live field compare
    // [RULE2] participation per field
    // [RULE5] independent field terms
    wire logic hitMon  = fieldHit(alarmReg.month, liveCal.month);
    wire logic hitDate = fieldHit(alarmReg.date, liveCal.date);
    wire logic hitHour = fieldHit(alarmReg.hour, liveCal.hour);
    wire logic hitMin  = fieldHit(alarmReg.minute, liveCal.minute);
    wire logic hitSec  = fieldHit(alarmReg.second, liveCal.second);
    // [RULE3] all-ones matches always
    // [RULE4] rates follow participation
    wire logic matchAll = hitMon & hitDate & hitHour & hitMin & hitSec;

    // [RULE16] once per second update
    // [RULE6] armed match sets
    wire logic setFlag = secTick & matchAll & armReg;
    // [RULE7] only zero write clears
    wire logic clrFlag = wrCtrl & ~wd[`RAP_BIT_FLAG];
    // [RULE8] disarm keeps flag
    wire logic flagNext = setFlag | (flagReg & ~clrFlag);
    wire logic statNext = setFlag | (statReg & ~(wrStat & wd[`RAP_BIT_EVT]));

    // [RULE11] wave rate choice
    wire logic waveSel = (rateReg == `RAP_RATE_1HZ)   ? waveSync.w1   :
                         (rateReg == `RAP_RATE_512HZ) ? waveSync.w512 :
                         (rateReg == `RAP_RATE_4KHZ)  ? waveSync.w4k  :
                                                        waveSync.w32k;

    // [RULE9] pin function table
    // [RULE12] calibration overrides pin
    // [RULE13] waves hide alarm
    // [RULE15] returns when calibration ends
    // [RULE10] select routes alarm
    // [RULE17] low while flagged
    wire logic alarmSel = ~calReg & pselReg & armReg;
    wire logic pinOeNext = calReg | ~pselReg | (alarmSel & flagReg);
    wire logic pinOutNext = calReg ? waveSync.w512 :
                            ~pselReg ? waveSel : 1'h1 & ~(alarmSel & flagReg);

    wire logic [31:0] rdMux =
        (addr == `RAP_OFS_CTRL)  ? {25'h0, flagReg, 3'h0, calReg, 2'h0} :
        (addr == `RAP_OFS_COMP)  ? {25'h0, pselReg, rateReg, 4'h0} :
        (addr == `RAP_OFS_ARM)   ? {31'h0, armReg} :
        (addr == `RAP_OFS_AMON)  ? {24'h0, alarmReg.month} :
        (addr == `RAP_OFS_ADATE) ? {24'h0, alarmReg.date} :
        (addr == `RAP_OFS_AHOUR) ? {24'h0, alarmReg.hour} :
        (addr == `RAP_OFS_AMIN)  ? {24'h0, alarmReg.minute} :
        (addr == `RAP_OFS_ASEC)  ? {24'h0, alarmReg.second} :
        (addr == `RAP_OFS_STAT)  ? {31'h0, statReg} :
        (addr == `RAP_OFS_MASK)  ? {31'h0, maskReg} :
                                   `RAP_RST_WORD;

    // One wait cycle: waitrequest drops for exactly the edge that completes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitReqReg <= 1'h1;
            rdataReg   <= `RAP_RST_WORD;
        end else begin
            waitReqReg <= ~(req & waitReqReg);
            if (rdTake) begin
                rdataReg <= rdMux;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flagReg <= `RAP_RST_BIT;
            statReg <= `RAP_RST_BIT;
            irqReg  <= `RAP_RST_BIT;
        end else begin
            flagReg <= flagNext;
            statReg <= statNext;
            irqReg  <= statReg & maskReg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calReg  <= `RAP_RST_BIT;
            pselReg <= `RAP_RST_BIT;
            rateReg <= `RAP_RST_RATE;
            armReg  <= `RAP_RST_BIT;
            maskReg <= `RAP_RST_BIT;
        end else begin
            if (wrCtrl) begin
                calReg <= wd[`RAP_BIT_CAL];
            end
            if (wrComp) begin
                pselReg <= wd[`RAP_BIT_PSEL];
                rateReg <= wd[`RAP_BIT_RATE_HI:`RAP_BIT_RATE_LO];
            end
            if (wrArm) begin
                armReg <= wd[`RAP_BIT_ARM];
            end
            if (wrMask) begin
                maskReg <= wd[`RAP_BIT_EVT];
            end
        end
    end

    // Unused alarm fields start out of the comparison.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmReg <= {5{`RAP_RST_FIELD}};
        end else begin
            if (wrAMon) begin
                alarmReg.month <= wd;
            end
            if (wrADat) begin
                alarmReg.date <= wd;
            end
            if (wrAHr) begin
                alarmReg.hour <= wd;
            end
            if (wrAMin) begin
                alarmReg.minute <= wd;
            end
            if (wrASec) begin
                alarmReg.second <= wd;
            end
        end
    end

    // The 32 kHz wave is sampled at 40 MHz, so its duty cycle jitters by a cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waveMeta  <= '0;
            waveSync  <= '0;
            pinOutReg <= 1'h1;
            pinOeReg  <= 1'h0;
        end else begin
            waveMeta  <= waveIn;
            waveSync  <= waveMeta;
            pinOutReg <= pinOutNext;
            pinOeReg  <= pinOeNext;
        end
    end

    assign avs_readdata    = rdataReg;
    assign avs_waitrequest = waitReqReg;
    assign alarmWavePinOut = pinOutReg;
    assign alarmWavePinOe  = pinOeReg;
    assign irq             = irqReg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_tickHit;
        secTick && matchAll && armReg;
    endsequence

    sequence s_ack;
        !waitReqReg ##1 waitReqReg;
    endsequence

    property p_flagSet;
        s_tickHit |=> flagReg;
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("match did not set flag"); // [RULE6]

    property p_flagCause;
        $rose(flagReg) |-> $past(secTick) && $past(matchAll) && $past(armReg);
    endproperty
    a_flagCause: assert property (p_flagCause) else $error("flag rose without armed match"); // [RULE8]

    property p_flagHold;
        flagReg && !clrFlag |=> flagReg;
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("flag dropped without clear"); // [RULE7]

    property p_everySec;
        secTick && armReg && (&{alarmReg.month[7], alarmReg.date[7], alarmReg.hour[7],
                                alarmReg.minute[7], alarmReg.second[7]}) |=> flagReg;
    endproperty
    a_everySec: assert property (p_everySec) else $error("free alarm missed a second"); // [RULE3]

    property p_miss;
        secTick && !alarmReg.second[7] && !hitSec && !flagReg |=> !flagReg;
    endproperty
    a_miss: assert property (p_miss) else $error("seconds mismatch set flag"); // [RULE4]

    property p_cal;
        calReg |=> pinOeReg && (pinOutReg == $past(waveSync.w512));
    endproperty
    a_cal: assert property (p_cal) else $error("calibration wave not on pin"); // [RULE12]

    property p_wave;
        !calReg && !pselReg |=> pinOeReg && (pinOutReg == $past(waveSel));
    endproperty
    a_wave: assert property (p_wave) else $error("selected wave not on pin"); // [RULE11]

    property p_alarmLow;
        alarmSel && flagReg |=> pinOeReg && !pinOutReg;
    endproperty
    a_alarmLow: assert property (p_alarmLow) else $error("alarm pin not driven low"); // [RULE17]

    property p_hiZ;
        !calReg && pselReg && !armReg |=> !pinOeReg;
    endproperty
    a_hiZ: assert property (p_hiZ) else $error("pin driven while disarmed"); // [RULE9]

    property p_bus;
        req && waitReqReg |=> s_ack;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer not after one wait cycle");

    property p_irq;
        statReg && maskReg |=> irqReg;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked status did not raise irq");

    // An exact date-and-time alarm: every field takes part in the compare.
    sequence s_allPart;
        !(alarmReg.month[`RAP_BIT_PART] | alarmReg.date[`RAP_BIT_PART] |
          alarmReg.hour[`RAP_BIT_PART] | alarmReg.minute[`RAP_BIT_PART] |
          alarmReg.second[`RAP_BIT_PART]);
    endsequence

    property p_exact;
        s_allPart ##0 (secTick && armReg && (liveCal == alarmReg)) |=> flagReg;
    endproperty
    a_exact: assert property (p_exact) else $error("exact match missed"); // [RULE4]

    property p_monMiss;
        secTick && !alarmReg.month[`RAP_BIT_PART] && !flagReg &&
        (alarmReg.month[`RAP_VAL_MSB:0] != liveCal.month[`RAP_VAL_MSB:0]) |=> !flagReg;
    endproperty
    a_monMiss: assert property (p_monMiss) else $error("month mismatch set flag"); // [RULE5]

    property p_flagClear;
        clrFlag && !setFlag |=> !flagReg;
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("flag not cleared"); // [RULE7]

    property p_disarmNoSet;
        !armReg && !flagReg |=> !flagReg;
    endproperty
    a_disarmNoSet: assert property (p_disarmNoSet) else $error("disarmed flag set"); // [RULE8]

    property p_release;
        alarmSel && !flagReg |=> !pinOeReg;
    endproperty
    a_release: assert property (p_release) else $error("idle alarm pin driven"); // [RULE17]

    property p_selWrite;
        wrComp |=> pselReg == $past(wd[`RAP_BIT_PSEL]);
    endproperty
    a_selWrite: assert property (p_selWrite) else $error("pin select not written"); // [RULE10]

    property p_calWrite;
        wrCtrl |=> calReg == $past(wd[`RAP_BIT_CAL]);
    endproperty
    a_calWrite: assert property (p_calWrite) else $error("calibration not written"); // [RULE15]

    property p_statClr;
        wrStat && wd[`RAP_BIT_EVT] && !setFlag |=> !statReg;
    endproperty
    a_statClr: assert property (p_statClr) else $error("status bit not cleared");

endmodule

// ---- testbench/rap_host_model.sv ----
/*
 * Host side of the shared alarm and wave pin: the line with its pull-up,
 * as the host's interrupt input sees it.
 * Assumes the pin level and enable come straight from the block.
 */
`timescale 1ns/1ps
module rap_host_model (
    // Pin from the block
    input  wire logic pinOut,
    input  wire logic pinOe,
    // Host view
    output logic      pinWire,
    output logic      alarmSeen
);
    // Pin watched as interrupt.
    // The pull-up keeps a released line high, so a stale level never shows.
    assign pinWire   = pinOe ? pinOut : 1'b1;
    assign alarmSeen = ~pinWire;
endmodule

// ---- testbench/rtc_alarm_and_pin_output_select_bench.sv ----
/*
 * Self-checking bench of the alarm matcher and pin selector.
 * Assumes one 40 MHz clock and a register slave with one wait state.
 */
`timescale 1ns/1ps
`include "rap_params.svh"
module rtc_alarm_and_pin_output_select_bench
    import rap_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    rap_cal_t    liveCal = '0;
    logic        secTick = 1'b0;
    rap_wave_t   waveIn = '0;
    logic        pinOut, pinOe, irq, pinWire, alarmSeen, hit;
    logic [31:0] q;
    logic [39:0] al, c;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;

    always #12.5 clk = ~clk;

    rap_alarm_pin #(.ADDR_W(8)) uut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .liveCal(liveCal), .secTick(secTick),
        .waveIn(waveIn), .alarmWavePinOut(pinOut), .alarmWavePinOe(pinOe), .irq(irq)
    );

    rap_host_model host (
        .pinOut(pinOut), .pinOe(pinOe), .pinWire(pinWire), .alarmSeen(alarmSeen)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= {24'h0, d};
        // The request stands until the rising edge at which waitrequest is seen low.
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask

    task automatic settle();
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tick();
        @(posedge clk);
        secTick <= 1'b1;
        @(posedge clk);
        secTick <= 1'b0;
        settle();
    endtask

    task automatic pin(input logic [1:0] e);
        chk({30'h0, pinOe, pinWire}, {30'h0, e});
    endtask

    task automatic load(input logic [39:0] a);
        for (int f = 0; f < 5; f++)
            bus(1'b1, 8'h30 - 8'(4 * f), a[f*8+:8]);
    endtask

    function automatic logic exp_hit(input logic [39:0] a, input logic [39:0] l);
        exp_hit = 1'b1;
        for (int f = 0; f < 5; f++)
            if (!a[f*8+7] && a[f*8+:7] != l[f*8+:7]) exp_hit = 1'b0;
    endfunction

    task automatic print_verdict();
        $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        q = $urandom(32'hB97F8CF0);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(`RAP_OFS_AMON, 32'h80);
        rd(`RAP_OFS_CTRL, 32'h0);
        rd(8'h3C, 32'h0);
        avs_byteenable <= 4'h0;
        bus(1'b1, `RAP_OFS_COMP, 8'h70);
        avs_byteenable <= 4'hF;
        rd(`RAP_OFS_COMP, 32'h0);
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, `RAP_OFS_COMP, 8'(r << 4));
            repeat (4) begin
                @(posedge clk);
                waveIn <= rap_wave_t'(4'($urandom));
                settle();
                pin({1'b1, waveIn[r]});
            end
        end
        bus(1'b1, `RAP_OFS_ARM, 8'h01);
        bus(1'b1, `RAP_OFS_MASK, 8'h01);
        bus(1'b1, `RAP_OFS_COMP, 8'h40);
        // The first six passes walk the documented rates, pass five an exact match.
        for (int i = 0; i < 16; i++) begin
            for (int f = 0; f < 5; f++) begin
                al[f*8+:8] = {(i < 6) ? 1'(f >= i) : 1'($urandom), 7'($urandom)};
                c[f*8+:8] = {1'b0, (i == 5 || 1'($urandom)) ? al[f*8+:7] : 7'($urandom)};
            end
            load(al);
            liveCal <= c;
            tick();
            hit = exp_hit(al, c);
            pin({hit, ~hit});
            chk({31'h0, irq}, {31'h0, hit});
            rd(`RAP_OFS_CTRL, {25'h0, hit, 6'h0});
            rd(`RAP_OFS_STAT, {31'h0, hit});
            bus(1'b1, `RAP_OFS_CTRL, 8'h00);
            bus(1'b1, `RAP_OFS_STAT, 8'h01);
            settle();
            pin(2'b01);
            chk({31'h0, irq}, 32'h0);
        end
        load(40'h80_80_80_80_80);
        tick();
        rd(`RAP_OFS_CTRL, 32'h40);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `RAP_OFS_ARM, 8'h00);
        settle();
        pin(2'b01);
        rd(`RAP_OFS_CTRL, 32'h40);
        bus(1'b1, `RAP_OFS_CTRL, 8'h00);
        tick();
        rd(`RAP_OFS_CTRL, 32'h0);
        bus(1'b1, `RAP_OFS_MASK, 8'h00);
        bus(1'b1, `RAP_OFS_ARM, 8'h01);
        tick();
        tick();
        pin(2'b10);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `RAP_OFS_CTRL, 8'h44);
        waveIn <= rap_wave_t'(4'h2);
        settle();
        pin(2'b11);
        bus(1'b1, `RAP_OFS_CTRL, 8'h04);
        tick();
        rd(`RAP_OFS_CTRL, 32'h44);
        bus(1'b1, `RAP_OFS_CTRL, 8'h40);
        settle();
        pin(2'b10);
        chk({31'h0, alarmSeen}, 32'h1);
        print_verdict();
    end
endmodule
